// >>> pcb_bus_master.sv
// Processor side of the pipelined memory bus: address phase, data phase, bursts.
// Assumes the core holds its request until bus_cycle_extend is high at a clock edge.
// Contract
// RL1: Cycle type codes: internal, coprocessor, nonsequential, sequential.
// RL2: Controller accesses memory only on N or S.
// RL3: N cycle: address now, data next cycle.
// RL4: Controller stretches back-to-back N cycles via extend. The model stretches only when the bench drives hold.
// RL5: Burst address steps four or two bytes.
// RL6: Byte transfers never form a burst.
// RL7: Burst starts N or merged; attributes constant.
// RL8: Merged internal cycle presents next S address.
// RL9: Controller never commits during internal cycles.
// RL10: Controller ignores coprocessor transfer cycles. The model answers coprocessor reads with 32'h1234_5678.
// RL11: Memory ignores low address bits per width.
// RL12: Direction high writes, constant in burst.
// RL13: Size codes byte, halfword, word; burst-constant.
// RL14: Writable memory needs per-byte write enables.
// RL15: Protection: upper privileged, lower data access.
// RL16: Lock high during atomic swap pair.
// RL17: Instruction state low 32-bit, high 16-bit.
// RL18: Write data valid in write cycles only.
// RL19: Read data sampled at bus cycle end.
// RL20: Abort sampled only ending N/S cycles.
// RL21: Data abort traps; fetch abort tagged.
// RL22: Everything on rising edge of clock.
// RL23: Cycle completes only when extend high.
`timescale 1ns/1ps
`default_nettype none
module pcb_bus_master (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Core request, taken at an edge with bus_cycle_extend high; state16 taken at every edge
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic [31:0] req_addr,
	input wire logic [1:0] req_size,
	input wire logic req_write,
	input wire logic req_priv,
	input wire logic req_data,
	input wire logic req_seq,
	input wire logic req_merge,
	input wire logic req_lock,
	input wire logic [31:0] req_wdata,
	input wire logic state16,
	// Core execute feedback for fetch aborts
	input wire logic exec_valid,
	input wire logic exec_fetch_abort,
	// Bus inputs
	input wire logic bus_cycle_extend,
	input wire logic [31:0] rdata,
	input wire logic abort,
	// Bus address class and request outputs
	output logic [1:0] bus_cycle_type,
	output logic [31:0] addr,
	output logic write,
	output logic [1:0] size,
	output logic [1:0] access_protection,
	output logic lock,
	output logic instr_set_state,
	// Bus write data
	output logic [31:0] wdata,
	// Core response
	output logic rsp_valid,
	output logic [31:0] rsp_rdata,
	output logic rsp_fetch_abort,
	output logic data_abort_trap,
	output logic prefetch_abort_trap
);
	import pcb_pkg::*;

	logic [1:0] cyc_q, cyc_d;
	logic [31:0] addr_q, addr_d;
	logic write_q, write_d;
	logic [1:0] size_q, size_d;
	logic [1:0] prot_q, prot_d;
	logic lock_q, lock_d;
	logic merged_q, merged_d;
	logic live_q, live_d;
	logic [31:0] wbuf_q;
	logic [1:0] dcyc_q;
	logic dwrite_q;
	logic ddata_q;
	logic [31:0] wdata_q;
	logic rsp_valid_q;
	logic [31:0] rsp_rdata_q;
	logic tset_q;
	logic seq_ok;
	logic advance;
	logic sample_mem;

	assign advance = bus_cycle_extend; // RL23

	// Sequential only when width, direction and protection match the open burst
	assign seq_ok = req_seq && live_q && (req_size != SZ_BYTE) // RL6
		&& (req_size == size_q) && (req_write == write_q)
		&& ({req_priv, req_data} == prot_q); // RL7

	// Next address phase
	always_comb begin
		cyc_d = CYC_INT;
		addr_d = addr_q;
		write_d = write_q;
		size_d = size_q;
		prot_d = prot_q;
		lock_d = 1'b0;
		merged_d = 1'b0;
		live_d = 1'b0;
		if (req_valid) begin
			write_d = req_write; // RL12
			size_d = req_size; // RL13
			prot_d = {req_priv, req_data}; // RL15
			lock_d = req_lock; // RL16
			case (req_kind)
				KIND_INT: begin
					cyc_d = CYC_INT; // RL1
					if (req_merge) begin
						addr_d = req_addr; // RL8
						merged_d = 1'b1;
						live_d = (req_size != SZ_BYTE);
					end
				end
				KIND_COP: begin
					cyc_d = CYC_COP; // RL1
				end
				default: begin
					live_d = (req_size != SZ_BYTE); // RL6
					if (seq_ok) begin
						cyc_d = CYC_SEQ; // RL1
						// Merged cycle already shows the location; else step on
						addr_d = merged_q ? addr_q : addr_q + pcb_step(size_q); // RL5 RL8
					end else begin
						cyc_d = CYC_NSEQ; // RL3
						addr_d = req_addr;
					end
				end
			endcase
		end
	end

	// Address phase registers, moved only at completed bus cycles
	always_ff @(posedge mclk) begin
		if (reset) begin
			cyc_q <= CYC_INT;
			addr_q <= ADDR_RST;
			write_q <= 1'b0;
			size_q <= SZ_WORD;
			prot_q <= PROT_RST;
			lock_q <= 1'b0;
			merged_q <= 1'b0;
			live_q <= 1'b0;
			wbuf_q <= DATA_RST;
		end else if (advance) begin // RL22 RL23
			cyc_q <= cyc_d;
			addr_q <= addr_d;
			write_q <= write_d;
			size_q <= size_d;
			prot_q <= prot_d;
			lock_q <= lock_d;
			merged_q <= merged_d;
			live_q <= live_d;
			wbuf_q <= req_wdata;
		end
	end

	// Data phase follows the address phase by one bus cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			dcyc_q <= CYC_INT;
			dwrite_q <= 1'b0;
			ddata_q <= 1'b0;
			wdata_q <= DATA_RST;
		end else if (advance) begin // RL3
			dcyc_q <= cyc_q;
			dwrite_q <= write_q;
			ddata_q <= prot_q[0];
			// Write data only for write cycles to memory or coprocessor
			if (write_q && (pcb_is_mem(cyc_q) || cyc_q == CYC_COP)) begin
				wdata_q <= wbuf_q; // RL18
			end else begin
				wdata_q <= DATA_RST; // RL18
			end
		end
	end

	// Read data captured at the edge ending the data phase
	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= DATA_RST;
		end else begin
			rsp_valid_q <= advance && !dwrite_q
				&& (pcb_is_mem(dcyc_q) || dcyc_q == CYC_COP); // RL19
			if (advance) begin
				rsp_rdata_q <= rdata; // RL19
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			tset_q <= 1'b0;
		end else begin
			tset_q <= state16; // RL17
		end
	end

	assign sample_mem = advance && pcb_is_mem(dcyc_q); // RL20

	pcb_abort_track u_abort (
		.mclk(mclk),
		.reset(reset),
		.sample_en(sample_mem),
		.data_access(ddata_q),
		.abort(abort),
		.exec_valid(exec_valid),
		.exec_fetch_abort(exec_fetch_abort),
		.data_abort_trap(data_abort_trap),
		.fetch_abort_tag(rsp_fetch_abort),
		.prefetch_abort_trap(prefetch_abort_trap)
	);

	assign bus_cycle_type = cyc_q;
	assign addr = addr_q;
	assign write = write_q;
	assign size = size_q;
	assign access_protection = prot_q;
	assign lock = lock_q;
	assign instr_set_state = tset_q;
	assign wdata = wdata_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = rsp_rdata_q;

	a_seq_no_byte: assert property (@(posedge mclk) disable iff (reset)
		(cyc_q == CYC_SEQ) |-> (size_q != SZ_BYTE)) // RL6
		else $error("sequential cycle with byte size");

	a_burst_step: assert property (@(posedge mclk) disable iff (reset)
		(advance && pcb_is_mem(cyc_q)) ##1 (cyc_q == CYC_SEQ)
		|-> addr_q == $past(addr_q, 1) + pcb_step($past(size_q, 1))) // RL5
		else $error("burst address step wrong");

	a_burst_attrs: assert property (@(posedge mclk) disable iff (reset)
		(advance && pcb_is_mem(cyc_q)) ##1 (cyc_q == CYC_SEQ)
		|-> (write_q == $past(write_q)) && (size_q == $past(size_q))
		&& (prot_q == $past(prot_q))) // RL7
		else $error("burst attributes changed");

	a_merge_same: assert property (@(posedge mclk) disable iff (reset)
		(advance && cyc_q == CYC_INT && merged_q) ##1 (cyc_q == CYC_SEQ)
		|-> $stable(addr_q)) // RL8
		else $error("merged cycle address not reused");

	a_extend_hold: assert property (@(posedge mclk) disable iff (reset)
		!bus_cycle_extend |=> $stable(cyc_q) && $stable(addr_q) && $stable(wdata_q)) // RL23
		else $error("bus changed while cycle extended");

	a_kind_code: assert property (@(posedge mclk) disable iff (reset)
		(advance && req_valid && req_kind == KIND_COP) |=> (cyc_q == CYC_COP)) // RL1
		else $error("coprocessor request not coded as coprocessor cycle");

	a_prot_lock: assert property (@(posedge mclk) disable iff (reset)
		(advance && req_valid) |=> (prot_q == {$past(req_priv), $past(req_data)})
		&& (lock_q == $past(req_lock))) // RL15 RL16
		else $error("protection or lock not taken from request");

	a_wdata_read: assert property (@(posedge mclk) disable iff (reset)
		(!dwrite_q && $past(advance)) |-> (wdata_q == DATA_RST)) // RL18
		else $error("write data driven in read cycle");

	a_rdata_cap: assert property (@(posedge mclk) disable iff (reset)
		rsp_valid_q |-> (rsp_rdata_q == $past(rdata)) && $past(advance)) // RL19
		else $error("read data not sampled at cycle end");

	a_abort_mem: assert property (@(posedge mclk) disable iff (reset)
		data_abort_trap |-> $past(advance && pcb_is_mem(dcyc_q) && abort && ddata_q)) // RL20 RL21
		else $error("data abort outside active memory cycle");

	a_state_flag: assert property (@(posedge mclk) disable iff (reset)
		##1 (instr_set_state == $past(state16))) // RL17
		else $error("instruction state flag does not follow core");
endmodule
`default_nettype wire

// >>> pcb_pkg.sv
// Constants for the pipelined processor memory bus interface.
// Assumes a single 10 MHz clock; all encodings are fixed two-bit codes.
package pcb_pkg;
	// Bus cycle type codes
	localparam logic [1:0] CYC_INT = 2'h0;
	localparam logic [1:0] CYC_COP = 2'h1;
	localparam logic [1:0] CYC_NSEQ = 2'h2;
	localparam logic [1:0] CYC_SEQ = 2'h3;
	// Transfer width codes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// Burst address steps in bytes
	localparam logic [31:0] STEP_WORD = 32'h0000_0004;
	localparam logic [31:0] STEP_HALF = 32'h0000_0002;
	// Core-side request kinds
	localparam logic [1:0] KIND_INT = 2'h0;
	localparam logic [1:0] KIND_COP = 2'h1;
	localparam logic [1:0] KIND_MEM = 2'h2;
	// Values after reset
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [1:0] PROT_RST = 2'h2;

	function automatic logic [31:0] pcb_step(input logic [1:0] size);
		pcb_step = (size == SZ_WORD) ? STEP_WORD : STEP_HALF;
	endfunction

	function automatic logic pcb_is_mem(input logic [1:0] cyc);
		pcb_is_mem = (cyc == CYC_NSEQ) || (cyc == CYC_SEQ);
	endfunction
endpackage

// >>> pcb_abort_track.sv
// Abort tracking for the memory bus interface.
// Assumes the caller gives a sample strobe only at the end of an active memory cycle.
`timescale 1ns/1ps
`default_nettype none
module pcb_abort_track (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// End of an active memory data phase
	input wire logic sample_en,
	input wire logic data_access,
	input wire logic abort,
	// Instruction leaving execute, with the abort tag it carried
	input wire logic exec_valid,
	input wire logic exec_fetch_abort,
	// Results
	output logic data_abort_trap,
	output logic fetch_abort_tag,
	output logic prefetch_abort_trap
);
	import pcb_pkg::*;

	// Data side traps at once; opcode side is only tagged
	always_ff @(posedge mclk) begin
		if (reset) begin
			data_abort_trap <= 1'b0;
			fetch_abort_tag <= 1'b0;
		end else begin
			data_abort_trap <= sample_en && data_access && abort; // RL21
			fetch_abort_tag <= sample_en && !data_access && abort; // RL21
		end
	end

	// Prefetch trap only when the tagged instruction really executes
	always_ff @(posedge mclk) begin
		if (reset) begin
			prefetch_abort_trap <= 1'b0;
		end else begin
			prefetch_abort_trap <= exec_valid && exec_fetch_abort; // RL21
		end
	end
endmodule
`default_nettype wire

// >>> pcb_mem_model.sv
// Memory controller model for the pipelined bus: stretches cycles and answers reads.
// Assumes it shares mclk and reset with the bus master and sees its registered outputs.
`timescale 1ns/1ps
`default_nettype none
module pcb_mem_model
	import pcb_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Bus from the master
	input wire logic [1:0] bus_cycle_type,
	input wire logic [31:0] addr,
	input wire logic write,
	input wire logic [1:0] size,
	input wire logic [31:0] wdata,
	// Bench controls
	input wire logic hold,
	input wire logic abort_req,
	// Answers
	output logic bus_cycle_extend,
	output logic [31:0] rdata,
	output logic abort
);
	logic [1:0] dp_t_q;
	logic [31:0] dp_a_q;
	logic dp_w_q;
	logic [1:0] dp_s_q;
	logic [3:0] be_w;
	logic [7:0] mem_q [0:63];
	logic [15:0] cnt_q;
	// Byte write enables derived from width and low address bits
	function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] lo);
		lanes = (sz == SZ_WORD) ? 4'hF : (sz == SZ_HALF) ? (lo[1] ? 4'hC : 4'h3) : (4'h1 << lo);
	endfunction
	assign be_w = lanes(dp_s_q, dp_a_q[1:0]);
	// Writes land byte by byte at the edge that ends the write data phase
	always_ff @(posedge mclk) begin
		if (!reset && bus_cycle_extend && dp_w_q && dp_t_q[1]) begin
			for (int i = 0; i < 4; i++) begin
				if (be_w[i])
					mem_q[{dp_a_q[5:2], 2'(i)}] <= wdata[8 * i +: 8];
			end
		end
	end
	always_ff @(posedge mclk) begin
		bus_cycle_extend <= reset | ~hold;
		if (reset) begin
			cnt_q <= 16'h0;
			dp_t_q <= CYC_INT;
			dp_w_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h1;
			if (bus_cycle_extend) begin
				dp_t_q <= bus_cycle_type;
				dp_a_q <= addr;
				dp_w_q <= write;
				dp_s_q <= size;
			end
		end
	end
	// Outside a read data phase the bus shows a moving pattern
	always_comb begin
		rdata = {cnt_q, ~cnt_q};
		if (!dp_w_q && dp_t_q == CYC_COP)
			rdata = 32'h1234_5678;
		else if (!dp_w_q && dp_t_q[1])
			rdata = {dp_a_q[31:2], 2'h0} ^ 32'h5A5A_0000;
	end
	assign abort = abort_req;
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the bus master facing a memory controller model.
// Assumes pcb_pkg; each valid request is checked in its address phase, reads and data aborts also in their data phase.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pcb_pkg::*;
	typedef struct {logic [1:0] t; logic [31:0] a; logic ca; logic m; logic [1:0] sz; logic w;
		logic [1:0] pr; logic lk; logic th; logic [31:0] wd;} pcb_anote_t;
	typedef struct {logic rv; logic [31:0] d; logic fa; logic dt;} pcb_rnote_t;
	logic mclk, reset, req_valid, req_write, req_priv, req_data, req_seq, req_merge, req_lock;
	logic [1:0] req_kind, req_size, bus_cycle_type, size, access_protection, o_sz, o_pr;
	logic [31:0] req_addr, req_wdata, rdata, addr, wdata, rsp_rdata, o_a, o_wd, rs, hs;
	logic state16, exec_valid, exec_fetch_abort, bus_cycle_extend, abort, write, lock;
	logic instr_set_state, rsp_valid, rsp_fetch_abort, data_abort_trap, prefetch_abort_trap;
	logic hold, abort_req, slow, ab_p, o_open, o_mg, o_w, pv, th;
	int n_fail, checks_done, cyc;
	pcb_anote_t aq[$];
	pcb_rnote_t rq[$];
	pcb_bus_master pcb_bus_master_i (.mclk(mclk), .reset(reset), .req_valid(req_valid),
		.req_kind(req_kind), .req_addr(req_addr), .req_size(req_size), .req_write(req_write),
		.req_priv(req_priv), .req_data(req_data), .req_seq(req_seq), .req_merge(req_merge),
		.req_lock(req_lock), .req_wdata(req_wdata), .state16(state16),
		.exec_valid(exec_valid), .exec_fetch_abort(exec_fetch_abort),
		.bus_cycle_extend(bus_cycle_extend), .rdata(rdata), .abort(abort),
		.bus_cycle_type(bus_cycle_type), .addr(addr), .write(write), .size(size),
		.access_protection(access_protection), .lock(lock), .instr_set_state(instr_set_state),
		.wdata(wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_fetch_abort(rsp_fetch_abort), .data_abort_trap(data_abort_trap),
		.prefetch_abort_trap(prefetch_abort_trap));
	pcb_mem_model pcb_mem_model_i (.mclk(mclk), .reset(reset), .bus_cycle_type(bus_cycle_type),
		.addr(addr), .write(write), .size(size), .wdata(wdata), .hold(hold), .abort_req(abort_req),
		.bus_cycle_extend(bus_cycle_extend), .rdata(rdata), .abort(abort));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Random stretching of bus cycles, and the hang limit
	always @(posedge mclk) begin
		hs = xs(hs);
		hold <= slow & hs[3];
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up();
		end
	end
	// One request; notes of its expected phases are queued when the bus takes it
	task automatic go(input logic v, input logic [1:0] k, input logic [1:0] sz,
		input logic w, input logic sq, input logic mg, input logic dt, input logic lk,
		input logic ab);
		pcb_anote_t n;
		pcb_rnote_t r;
		logic [31:0] d;
		rs = xs(rs);
		d = xs(rs);
		n.m = v && k[1];
		n.t = (!v || k == KIND_INT) ? CYC_INT : (k == KIND_COP) ? CYC_COP : CYC_NSEQ;
		n.a = rs;
		n.ca = v && (n.m || (mg && k == KIND_INT));
		n.sz = sz;
		n.w = w;
		n.pr = {pv, dt};
		n.lk = lk;
		n.th = th;
		n.wd = o_wd;
		if (n.m && sq && o_open && sz == o_sz && w == o_w && n.pr == o_pr) begin
			n.t = CYC_SEQ;
			n.a = o_mg ? o_a : o_a + ((sz == SZ_WORD) ? STEP_WORD : STEP_HALF);
		end
		o_open = n.ca && sz != SZ_BYTE;
		o_mg = !n.m;
		o_a = n.a;
		o_sz = sz;
		o_w = w;
		o_pr = n.pr;
		o_wd = (v && w && k != KIND_INT) ? d : 32'h0;
		r.rv = v && k != KIND_INT && !w;
		r.d = k[1] ? {n.a[31:2], 2'h0} ^ 32'h5A5A_0000 : 32'h1234_5678;
		r.fa = n.m && !dt && ab;
		r.dt = n.m && dt && ab;
		req_valid <= v;
		req_kind <= k;
		req_addr <= rs;
		req_size <= sz;
		req_write <= w;
		req_priv <= pv;
		req_data <= dt;
		req_seq <= sq;
		req_merge <= mg;
		req_lock <= lk;
		req_wdata <= d;
		state16 <= th;
		for (int i = 0; i < 60; i++) begin
			@(posedge mclk);
			if (bus_cycle_extend === 1'b1)
				break;
		end
		abort_req <= ab_p;
		ab_p = v && ab;
		if (v)
			aq.push_back(n);
		if (r.rv || r.dt)
			rq.push_back(r);
	endtask
	always @(posedge mclk) begin
		pcb_anote_t n;
		pcb_rnote_t r;
		logic tk;
		tk = bus_cycle_extend & ~reset;
		#1;
		if (tk && aq.size() > 0) begin
			n = aq.pop_front();
			chk("type", n.t, bus_cycle_type);
			if (n.ca)
				chk("addr", n.a, addr);
			chk("wdata", n.wd, wdata);
			chk("isa", n.th, instr_set_state);
			if (n.m) begin
				chk("size", n.sz, size);
				chk("write", n.w, write);
				chk("prot", n.pr, access_protection);
				chk("lock", n.lk, lock);
			end
		end
		if (rsp_valid === 1'b1 || data_abort_trap === 1'b1) begin
			chk("rsp_note", 1, rq.size() > 0);
			r = rq.pop_front();
			chk("rsp", r.rv, rsp_valid);
			if (r.rv)
				chk("rdata", r.d, rsp_rdata);
			chk("fabort", r.fa, rsp_fetch_abort);
			chk("dabort", r.dt, data_abort_trap);
		end
	end
	task automatic suite();
		go(1, KIND_MEM, SZ_WORD, 0, 0, 0, 0, 0, 0);
		go(1, KIND_MEM, SZ_WORD, 0, 1, 0, 0, 0, 0);
		go(1, KIND_MEM, SZ_WORD, 0, 1, 0, 0, 0, 1);
		go(1, KIND_MEM, SZ_HALF, 0, 1, 0, 0, 0, 0);
		go(1, KIND_MEM, SZ_HALF, 0, 1, 0, 0, 0, 0);
		go(1, KIND_MEM, SZ_BYTE, 0, 1, 0, 1, 0, 0);
		go(1, KIND_MEM, SZ_BYTE, 0, 1, 0, 1, 0, 0);
		go(1, KIND_INT, SZ_WORD, 0, 0, 1, 1, 0, 0);
		go(1, KIND_MEM, SZ_WORD, 0, 1, 0, 1, 0, 0);
		go(1, KIND_INT, SZ_WORD, 0, 0, 0, 0, 0, 0);
		go(1, KIND_MEM, SZ_WORD, 0, 1, 0, 0, 0, 0);
		go(1, KIND_MEM, SZ_BYTE, 0, 0, 0, 1, 1, 0);
		go(1, KIND_MEM, SZ_BYTE, 1, 0, 0, 1, 1, 0);
		go(1, KIND_MEM, SZ_WORD, 1, 0, 0, 1, 0, 0);
		go(1, KIND_MEM, SZ_WORD, 1, 1, 0, 1, 0, 0);
		go(1, KIND_MEM, SZ_WORD, 1, 1, 0, 1, 0, 1);
		go(1, KIND_MEM, SZ_WORD, 0, 1, 0, 1, 0, 0);
		go(1, KIND_COP, SZ_WORD, 1, 0, 0, 1, 0, 0);
		go(1, KIND_COP, SZ_WORD, 0, 0, 0, 1, 0, 1);
		go(0, KIND_INT, SZ_WORD, 0, 0, 0, 0, 0, 0);
		go(0, KIND_INT, SZ_WORD, 0, 0, 0, 0, 0, 0);
		exec_valid <= 1'b1;
		exec_fetch_abort <= 1'b1;
		@(posedge mclk);
		exec_valid <= 1'b0;
		#1;
		chk("pabort", 1, prefetch_abort_trap);
		@(posedge mclk);
	endtask
	initial begin
		{reset, hold, slow, pv, th, ab_p, o_open, o_mg, o_w} = 9'h100;
		{req_valid, req_write, req_priv, req_data, req_seq, req_merge, req_lock} = 7'h0;
		{state16, exec_valid, exec_fetch_abort, abort_req} = 4'h0;
		{req_kind, req_size, o_sz, o_pr, req_addr, req_wdata, o_a, o_wd} = 136'h0;
		rs = 32'h3EA4_0550;
		hs = 32'h3EA4_0550;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			slow <= p[1];
			pv = p[0];
			th = p[0] ^ p[1];
			suite();
			$display("test %0d done", p);
		end
		repeat (4) @(posedge mclk);
		chk("left", 0, aq.size() + rq.size());
		wrap_up();
	end
endmodule
`default_nettype wire
